// ==== core/decoder_index_home_pin_mux.sv ====
// Function mux for the decoder index and home pins
`timescale 1ns/10ps
module decoder_index_home_pin_mux
	import index_home_mux_pkg::*;
#(
	parameter bit FULL_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Configuration
	input wire logic index_pin_spi_route,
	input wire logic home_pin_spi_route,
	input wire logic index_pin_timer_route,
	input wire logic home_pin_timer_route,
	input wire logic index_pin_port_route,
	input wire logic home_pin_port_route,
	input wire logic [index_home_mux_pkg::PUR_WIDTH-1:0] port_c_pullup_enable_reg,
	// Timer B channels two and three
	input wire logic timer_b_channel_two_out,
	input wire logic timer_b_channel_two_drive,
	output logic timer_b_channel_two_in,
	input wire logic timer_b_channel_three_out,
	input wire logic timer_b_channel_three_drive,
	output logic timer_b_channel_three_in,
	// SPI port two
	input wire logic spi_master_mode,
	input wire logic spi_data_out,
	output logic spi_port_two_data_in_out,
	output logic spi_port_two_slave_select,
	// Port C lines two and three
	input wire logic port_c_line_two_out,
	input wire logic port_c_line_two_dir_out,
	input wire logic port_c_line_three_out,
	input wire logic port_c_line_three_dir_out,
	output logic port_c_line_two,
	output logic port_c_line_three,
	// Decoder
	output logic decoder_index_pin,
	output logic decoder_home_pin,
	// Index pad
	input wire logic index_pad_in,
	output logic index_pad_out,
	output logic index_pad_oe_n,
	output logic index_pad_pullup,
	// Home pad
	input wire logic home_pad_in,
	output logic home_pad_out,
	output logic home_pad_oe_n,
	output logic home_pad_pullup
);
	import index_home_mux_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Function selection
	logic [1:0] index_fn, home_fn;
	logic [1:0] fn_default;
	logic cfg_touched_q, cfg_touched_d;
	logic any_route;

	assign any_route = index_pin_spi_route | home_pin_spi_route | index_pin_timer_route
		| home_pin_timer_route | index_pin_port_route | home_pin_port_route;
	// Reduced part parks on a port input until software programs a route
	assign fn_default = FULL_VARIANT ? 2'(FN_DECODER) : FN_RESET_REDUCED;

	always_comb begin
		cfg_touched_d = cfg_touched_q | any_route;
		if (!reset_n) begin
			cfg_touched_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		cfg_touched_q <= cfg_touched_d;
	end

	// SPI route outranks timer and port routes
	always_comb begin
		index_fn = fn_default;
		if (index_pin_spi_route) begin
			index_fn = 2'(FN_SPI);
		end else if (index_pin_timer_route) begin
			index_fn = 2'(FN_TIMER);
		end else if (index_pin_port_route) begin
			index_fn = 2'(FN_PORT);
		end
		home_fn = fn_default;
		if (home_pin_spi_route) begin
			home_fn = 2'(FN_SPI);
		end else if (home_pin_timer_route) begin
			home_fn = 2'(FN_TIMER);
		end else if (home_pin_port_route) begin
			home_fn = 2'(FN_PORT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SPI data-out enable
	logic ss_active;
	logic spi_drive;
	// Slave select is active low on the home pin
	assign ss_active = home_pin_spi_route & ~home_pad_in;
	// Slave drives only while addressed; master never drives, the index pin is then its data input
	assign spi_drive = spi_master_mode ? 1'b0 : ss_active;
	// Shift timing belongs to the SPI core: it presents each bit half a clock early
	// and this path adds one flop, kept small against the SPI bit period.

	////////////////////////////////////////////////////////////////////////
	// Pads
	pin_cell u_index (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.fn(index_fn),
		.pullup_en(port_c_pullup_enable_reg[PUR_INDEX_BIT]),
		.timer_out(timer_b_channel_two_out),
		.timer_drive(timer_b_channel_two_drive),
		.spi_out(spi_data_out),
		.spi_drive(spi_drive),
		.port_out(port_c_line_two_out),
		.port_drive(port_c_line_two_dir_out),
		.pad_in(index_pad_in),
		.pad_out(index_pad_out),
		.pad_oe_n(index_pad_oe_n),
		.pad_pullup(index_pad_pullup)
	);

	pin_cell u_home (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.fn(home_fn),
		.pullup_en(port_c_pullup_enable_reg[PUR_HOME_BIT]),
		.timer_out(timer_b_channel_three_out),
		.timer_drive(timer_b_channel_three_drive),
		.spi_out(1'b0),
		.spi_drive(1'b0),
		.port_out(port_c_line_three_out),
		.port_drive(port_c_line_three_dir_out),
		.pad_in(home_pad_in),
		.pad_out(home_pad_out),
		.pad_oe_n(home_pad_oe_n),
		.pad_pullup(home_pad_pullup)
	);

	////////////////////////////////////////////////////////////////////////
	// Inbound routing, registered; idle values are inactive levels
	logic idx_dec_d, hom_dec_d, tb2_d, tb3_d, miso_d, ss_d, pc2_d, pc3_d;

	always_comb begin
		idx_dec_d = (index_fn == 2'(FN_DECODER)) ? index_pad_in : 1'b0;
		hom_dec_d = (home_fn == 2'(FN_DECODER)) ? home_pad_in : 1'b0;
		tb2_d = (index_fn == 2'(FN_TIMER)) ? index_pad_in : 1'b0;
		tb3_d = (home_fn == 2'(FN_TIMER)) ? home_pad_in : 1'b0;
		miso_d = (index_fn == 2'(FN_SPI)) ? index_pad_in : 1'b0;
		// Unrouted select reads high: not selected, no master contention
		ss_d = (home_fn == 2'(FN_SPI)) ? home_pad_in : 1'b1;
		pc2_d = (index_fn == 2'(FN_PORT)) ? index_pad_in : 1'b0;
		pc3_d = (home_fn == 2'(FN_PORT)) ? home_pad_in : 1'b0;
		if (!reset_n) begin
			idx_dec_d = 1'b0;
			hom_dec_d = 1'b0;
			tb2_d = 1'b0;
			tb3_d = 1'b0;
			miso_d = 1'b0;
			ss_d = 1'b1;
			pc2_d = 1'b0;
			pc3_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		decoder_index_pin <= idx_dec_d;
		decoder_home_pin <= hom_dec_d;
		timer_b_channel_two_in <= tb2_d;
		timer_b_channel_three_in <= tb3_d;
		spi_port_two_data_in_out <= miso_d;
		spi_port_two_slave_select <= ss_d;
		port_c_line_two <= pc2_d;
		port_c_line_three <= pc3_d;
	end

	logic unused_touch;
	assign unused_touch = cfg_touched_q;

endmodule : decoder_index_home_pin_mux

// ==== core/index_home_mux_pkg.sv ====
// Constants and encodings for the decoder index/home pin multiplexer
// Notes on behaviour
// - With the index-pin SPI route bit set, the index pin carries the second SPI port's data-in/out line.
// - With the home-pin SPI route bit set, the home pin carries the second SPI port's slave-select line.
// - On the full-featured variant the index pin comes out of reset as the decoder index input.
// - On the full-featured variant the home pin comes out of reset as the decoder home input.
// - Clearing bit 2 of the port C pull-up enable register turns off the index pin pull-up.
// - Clearing bit 3 of the port C pull-up enable register turns off the home pin pull-up.
// - An SPI slave that is not selected leaves its data-out line undriven.
// - As a slave, each data-out bit is driven half a clock before the master samples it.
// - As SPI master, slave select is an input used to arbitrate between masters.
// - As SPI slave, slave select is the input that addresses this device.
// - As port lines, each pin is individually an input or an output.
// - As SPI master, the index pin is never driven; it carries the data coming in from the slave.
package index_home_mux_pkg;

	// Pin positions inside the port C pull-up register
	localparam int unsigned PUR_WIDTH = 8;
	localparam int unsigned PUR_INDEX_BIT = 2;
	localparam int unsigned PUR_HOME_BIT = 3;
	localparam logic [7:0] PUR_RESET = 8'hff;

	// Pin function encoding
	typedef enum logic [1:0] {
		FN_DECODER = 2'b00,
		FN_TIMER = 2'b01,
		FN_SPI = 2'b10,
		FN_PORT = 2'b11
	} pin_fn_e;

	// Reset function on the reduced variant: port line, input
	localparam logic [1:0] FN_RESET_REDUCED = 2'b11;

endpackage : index_home_mux_pkg

// ==== core/pin_cell.sv ====
// One multiplexed pin: function select, drive and pull-up
`timescale 1ns/10ps
module pin_cell
	import index_home_mux_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Selection
	input wire logic [1:0] fn,
	input wire logic pullup_en,
	// Candidate drivers per function, active high enable
	input wire logic timer_out,
	input wire logic timer_drive,
	input wire logic spi_out,
	input wire logic spi_drive,
	input wire logic port_out,
	input wire logic port_drive,
	// Pad
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_n,
	output logic pad_pullup
);
	logic out_d, oe_n_d, pu_d;

	always_comb begin
		out_d = 1'b0;
		oe_n_d = 1'b1;
		pu_d = pullup_en;
		unique case (pin_fn_e'(fn))
			FN_DECODER: begin
				oe_n_d = 1'b1;
			end
			FN_TIMER: begin
				out_d = timer_out;
				oe_n_d = ~timer_drive;
			end
			FN_SPI: begin
				out_d = spi_out;
				oe_n_d = ~spi_drive;
			end
			FN_PORT: begin
				out_d = port_out;
				oe_n_d = ~port_drive;
			end
		endcase
		if (!reset_n) begin
			out_d = 1'b0;
			oe_n_d = 1'b1;
			pu_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		pad_out <= out_d;
		pad_oe_n <= oe_n_d;
		pad_pullup <= pu_d;
	end

	// Pad input is unused here; consumers read it directly
	logic unused_in;
	assign unused_in = pad_in;

endmodule : pin_cell

// ==== verif/pin_mux_assertions.sv ====
// Port checks for the index/home pin mux
`timescale 1ns/10ps
module pin_mux_checker (
	input wire logic ref_clk, reset_n, index_pin_spi_route, home_pin_spi_route, index_pin_timer_route,
	input wire logic spi_master_mode, spi_data_out, timer_b_channel_two_out, timer_b_channel_two_drive,
	input wire logic [7:0] port_c_pullup_enable_reg,
	input wire logic spi_port_two_data_in_out, spi_port_two_slave_select, index_pad_in, index_pad_out,
	input wire logic index_pad_oe_n, index_pad_pullup, home_pad_in, home_pad_oe_n, home_pad_pullup
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire logic slave = index_pin_spi_route & home_pin_spi_route & !spi_master_mode;
	property p_sdrv; slave && !home_pad_in |=> !index_pad_oe_n && index_pad_out == $past(spi_data_out); endproperty
	a_sdrv: assert property (p_sdrv) else $error("slave data not driven");
	property p_sidle; slave && home_pad_in |=> index_pad_oe_n; endproperty
	a_sidle: assert property (p_sidle) else $error("unselected slave drives");
	property p_min; index_pin_spi_route && spi_master_mode |=> index_pad_oe_n ##0
		spi_port_two_data_in_out == $past(index_pad_in); endproperty
	a_min: assert property (p_min) else $error("master data in wrong");
	property p_sel; home_pin_spi_route |=> home_pad_oe_n && spi_port_two_slave_select == $past(home_pad_in); endproperty
	a_sel: assert property (p_sel) else $error("slave select wrong");
	property p_pui; 1'b1 |=> index_pad_pullup == $past(port_c_pullup_enable_reg[2]); endproperty
	a_pui: assert property (p_pui) else $error("index pull-up wrong");
	property p_puh; $fell(port_c_pullup_enable_reg[3]) |=> !home_pad_pullup; endproperty
	a_puh: assert property (p_puh) else $error("home pull-up stays on");
	property p_tmr; index_pin_timer_route && !index_pin_spi_route && timer_b_channel_two_drive |=>
		!index_pad_oe_n && index_pad_out == $past(timer_b_channel_two_out); endproperty
	a_tmr: assert property (p_tmr) else $error("timer drive wrong");
	// Own disable: this one must hold while reset is low
	property p_rst; disable iff (1'b0) !reset_n |=> index_pad_oe_n && home_pad_oe_n && index_pad_pullup
		&& home_pad_pullup; endproperty
	a_rst: assert property (p_rst) else $error("pins not released in reset");
	cover property (slave && !home_pad_in);
	cover property (index_pin_spi_route && spi_master_mode);
	cover property (!reset_n ##1 reset_n);
endmodule : pin_mux_checker
bind decoder_index_home_pin_mux pin_mux_checker i_pin_mux_checker (.*);

// ==== verif/pad_peer.sv ====
// Board side of one pad: peer driver, pull-up, floating level
`timescale 1ns/10ps
module pad_peer (
	input wire logic ref_clk, pad_out, pad_oe_n, pad_pullup, peer_en, peer_val,
	output logic level
);
	logic float_q = 1'b0;
	always @(posedge ref_clk) float_q <= !float_q;
	// Undriven without pull-up: toggles, never keeps the last value
	assign level = !pad_oe_n ? pad_out : peer_en ? peer_val : pad_pullup ? 1'b1 : float_q;
endmodule : pad_peer

// ==== verif/decoder_index_home_pin_mux_bench.sv ====
// Self-checking bench for the index/home pin mux
`timescale 1ns/10ps
module decoder_index_home_pin_mux_bench;
	logic ref_clk = 0, reset_n = 0, have = 0;
	logic index_pin_spi_route, home_pin_spi_route, index_pin_timer_route, home_pin_timer_route;
	logic index_pin_port_route, home_pin_port_route, spi_master_mode, spi_data_out, ien, ival, hen, hval;
	logic [7:0] port_c_pullup_enable_reg;
	logic timer_b_channel_two_out, timer_b_channel_two_drive, timer_b_channel_three_out, timer_b_channel_three_drive;
	logic port_c_line_two_out, port_c_line_two_dir_out, port_c_line_three_out, port_c_line_three_dir_out;
	logic timer_b_channel_two_in, timer_b_channel_three_in, spi_port_two_data_in_out, spi_port_two_slave_select;
	logic port_c_line_two, port_c_line_three, decoder_index_pin, decoder_home_pin;
	logic index_pad_in, index_pad_out, index_pad_oe_n, index_pad_pullup;
	logic home_pad_in, home_pad_out, home_pad_oe_n, home_pad_pullup;
	logic [27:0] stim = '0;
	logic [13:0] exp_v;
	integer seed = 86, miscompares = 0, total_checks = 0, cycles = 0;
	assign {index_pin_spi_route, home_pin_spi_route, spi_master_mode, index_pin_timer_route, home_pin_timer_route,
		index_pin_port_route, home_pin_port_route, port_c_pullup_enable_reg, timer_b_channel_two_out,
		timer_b_channel_two_drive, timer_b_channel_three_out, timer_b_channel_three_drive, spi_data_out,
		port_c_line_two_out, port_c_line_two_dir_out, port_c_line_three_out, port_c_line_three_dir_out,
		ien, ival, hen, hval} = stim;
	wire logic [13:0] act_v = {index_pad_oe_n, index_pad_out & !index_pad_oe_n, home_pad_oe_n,
		home_pad_out & !home_pad_oe_n, home_pad_pullup, index_pad_pullup, spi_port_two_data_in_out,
		spi_port_two_slave_select, timer_b_channel_two_in, timer_b_channel_three_in, port_c_line_two,
		port_c_line_three, decoder_index_pin, decoder_home_pin};
	decoder_index_home_pin_mux #(.FULL_VARIANT(1'b1)) i_decoder_index_home_pin_mux (.*);
	pad_peer i_pad_peer_index (.ref_clk, .pad_out(index_pad_out), .pad_oe_n(index_pad_oe_n),
		.pad_pullup(index_pad_pullup), .peer_en(ien), .peer_val(ival), .level(index_pad_in));
	pad_peer i_pad_peer_home (.ref_clk, .pad_out(home_pad_out), .pad_oe_n(home_pad_oe_n),
		.pad_pullup(home_pad_pullup), .peer_en(hen), .peer_val(hval), .level(home_pad_in));
	initial forever #2 ref_clk = !ref_clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [13:0] expect_v();
		logic is, it, ip, hs, ht, hp, id, hd;
		is = index_pin_spi_route;
		it = !is & index_pin_timer_route;
		ip = !is & !it & index_pin_port_route;
		hs = home_pin_spi_route;
		ht = !hs & home_pin_timer_route;
		hp = !hs & !ht & home_pin_port_route;
		id = is ? !spi_master_mode & hs & !home_pad_in : it ? timer_b_channel_two_drive : ip & port_c_line_two_dir_out;
		hd = ht ? timer_b_channel_three_drive : hp & port_c_line_three_dir_out;
		return {!id, id & (is ? spi_data_out : it ? timer_b_channel_two_out : port_c_line_two_out), !hd,
			hd & (ht ? timer_b_channel_three_out : port_c_line_three_out), port_c_pullup_enable_reg[3:2],
			is & index_pad_in, !hs | home_pad_in, it & index_pad_in, ht & home_pad_in, ip & index_pad_in,
			hp & home_pad_in, !(is | it | ip) & index_pad_in, !(hs | ht | hp) & home_pad_in};
	endfunction : expect_v
	task automatic check(input logic [13:0] act, input logic [13:0] exp);
		total_checks++;
		if (act !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : check
	// Mode 1 forces slave mode on both SPI routes (select stays random), mode 2 the reset function
	task automatic run(input int n, input int mode, input string name);
		repeat (n) begin
			@(negedge ref_clk);
			if (have) check(act_v, exp_v);
			stim = 28'($random(seed));
			if (mode == 1) stim[27:25] = 3'b110;
			if (mode == 2) {stim[27:26], stim[24:21]} = 6'h00;
			#1 exp_v = expect_v();
			have = 1;
		end
		$display("test %s done", name);
	endtask : run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		reset_n = 1;
		run(300, 2, "reset function");
		run(1500, 0, "random");
		run(400, 1, "slave select");
		@(negedge ref_clk);
		reset_n = 0;
		have = 0;
		@(negedge ref_clk);
		check({index_pad_oe_n, home_pad_oe_n, index_pad_pullup, home_pad_pullup, spi_port_two_slave_select, 9'h000},
			14'h3e00);
		repeat (19) @(negedge ref_clk);
		reset_n = 1;
		run(600, 0, "after second reset");
		stop_test();
	end
endmodule : decoder_index_home_pin_mux_bench
